// ==== rtl/bldc_pkg.sv ====
// constants and carrier types for the brushless speed loop controller
package bldc_pkg;

    // timing counts in pclk cycles at 200 MHz
    localparam int STOP_CLEAR_CYC = 200000;  // 1 ms
    localparam int SETTLE_CYC     = 2000000; // 10 ms
    localparam int CLK_LOSS_CYC   = 20000;   // 100 us
    localparam int DEAD_CYC       = 100;     // 500 ns gap

    localparam logic [7:0] OFS_PWM_PERIOD = 8'h00;
    localparam logic [7:0] OFS_STALL_TIME = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_ERRORS     = 8'h0c;

    // reset values: 20 kHz pwm, 2 s stall timeout
    localparam logic [15:0] RST_PWM_PERIOD = 16'h2710;
    localparam logic [31:0] RST_STALL_TIME = 32'h17d7_8400;

    localparam logic [10:0] CNT_256  = 11'h100;
    localparam logic [10:0] CNT_512  = 11'h200;
    localparam logic [10:0] CNT_1024 = 11'h400;

    // lock window is count / 16, i.e. 6.25 percent
    localparam int LOCK_SHIFT = 4;

    localparam int ST_POS_STATE  = 0;
    localparam int ST_POS_LOCKED = 2;
    localparam int ST_POS_CLKLOS = 3;
    localparam int ST_POS_UV     = 4;
    localparam int ST_POS_POR    = 5;
    localparam int ST_POS_DUTY   = 16;

    typedef struct packed {
        logic [2:0] hall;
        logic       tach;
        logic       refclk;
        logic       cur_lim;
        logic       por_ok;
        logic       uv_trip;
        logic       uv_release;
        logic       sel_a;
        logic       sel_b;
        logic       dir;
        logic       brake;
        logic       run_n;
    } pins_t;

    localparam logic [13:0] PINS_RST = 14'h0001;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } drive_t;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10,
        ST_STALL  = 2'b11
    } run_state_t;

endpackage

// ==== rtl/bldc_speed_loop_controller.sv ====
// speed loop, commutation and protection core with apb registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module bldc_speed_loop_controller #(
    parameter int STOP_CLEAR_CYC = bldc_pkg::STOP_CLEAR_CYC,
    parameter int SETTLE_CYC     = bldc_pkg::SETTLE_CYC,
    parameter int CLK_LOSS_CYC   = bldc_pkg::CLK_LOSS_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reference_clock_input,
    input  wire logic        tach_feedback,
    input  wire logic        hall_a_plus,
    input  wire logic        hall_b_plus,
    input  wire logic        hall_c_plus,
    input  wire logic        current_sense_input,
    input  wire logic        stall_timer_node,
    input  wire logic        supply_below_trip,
    input  wire logic        supply_above_release,
    input  wire logic        count_select_a,
    input  wire logic        count_select_b,
    input  wire logic        direction_select,
    input  wire logic        brake_select,
    input  wire logic        run_stop_n,
    output logic             phase_a_high_drive,
    output logic             phase_b_high_drive,
    output logic             phase_c_high_drive,
    output logic             phase_a_low_drive,
    output logic             phase_b_low_drive,
    output logic             phase_c_low_drive,
    output logic             speed_locked_flag_o,
    output logic             speed_locked_flag_oe,
    output logic             speed_error_valid,
    output logic      [15:0] speed_error,
    output logic             phase_error_valid,
    output logic      [15:0] phase_error
);

    typedef struct packed {
        bldc_pkg::pins_t      s1;
        bldc_pkg::pins_t      s2;
        bldc_pkg::pins_t      s3;
        bldc_pkg::pins_t      flt;
        logic                 ref_prev;
        logic                 tach_prev;
        logic                 dir_prev;
        logic                 brake_prev;
        logic [19:0]          ref_per_cnt;
        logic [19:0]          ref_per;
        logic [20:0]          nco_acc;
        logic [31:0]          loss_cnt;
        logic                 clk_lost;
        logic [15:0]          spd_cnt;
        logic [10:0]          ph_cnt;
        logic                 spd_skip;
        logic [15:0]          spd_err;
        logic                 spd_vld;
        logic [15:0]          ph_err;
        logic                 ph_vld;
        logic                 locked;
        logic                 lock_oe;
        logic [15:0]          duty;
        logic [15:0]          pwm_cnt;
        logic                 pwm_cut;
        logic                 uv;
        logic [31:0]          stall_cnt;
        logic [31:0]          stop_cnt;
        logic [31:0]          settle_cnt;
        logic [7:0]           dead_cnt;
        bldc_pkg::run_state_t st;
        logic [15:0]          pwm_period;
        logic [31:0]          stall_time;
        logic [31:0]          rdata;
        bldc_pkg::drive_t     drv;
    } state_t;

    // select pins read high when open; pull-ups sit outside the block
    function automatic logic [21:0] sel_decode(input logic a,
                                               input logic b);
        case ({a, b})
            2'b11:   sel_decode = {bldc_pkg::CNT_1024, bldc_pkg::CNT_1024};
            2'b10:   sel_decode = {bldc_pkg::CNT_1024, bldc_pkg::CNT_512};
            2'b01:   sel_decode = {bldc_pkg::CNT_256, bldc_pkg::CNT_256};
            default: sel_decode = {bldc_pkg::CNT_512, bldc_pkg::CNT_512};
        endcase
    endfunction

    function automatic bldc_pkg::drive_t commutate(input logic [2:0] h,
                                                  input logic       rev);
        bldc_pkg::drive_t d;
        case (h)
            3'b001:  d = '{high: 3'b001, low: 3'b010};
            3'b011:  d = '{high: 3'b001, low: 3'b100};
            3'b010:  d = '{high: 3'b010, low: 3'b100};
            3'b110:  d = '{high: 3'b010, low: 3'b001};
            3'b100:  d = '{high: 3'b100, low: 3'b001};
            3'b101:  d = '{high: 3'b100, low: 3'b010};
            default: d = '{high: 3'b000, low: 3'b000};
        endcase
        if (rev) begin
            d = '{high: d.low, low: d.high};
        end
        return d;
    endfunction

    function automatic logic [15:0] sat_duty(input logic [15:0] d,
                                             input logic [15:0] e);
        logic [17:0] sum;
        sum = {2'b00, d} + {{2{e[15]}}, e};
        sat_duty = sum[17] ? 16'h0000 : (sum[16] ? 16'hffff : sum[15:0]);
    endfunction

    state_t           s;
    state_t           n;
    bldc_pkg::pins_t  pins;
    bldc_pkg::drive_t comm;
    logic [10:0]      cnt_sel;
    logic [10:0]      div_sel;
    logic [15:0]      mag;
    logic [15:0]      win;
    logic             ref_edge;
    logic             tach_edge;
    logic             vco_tick;
    logic             pwm_on;
    logic             braking;
    logic             lock_now;
    logic             access;
    logic             mapped;

    assign pins = '{hall: {hall_c_plus, hall_b_plus, hall_a_plus},
                    tach: tach_feedback,
                    refclk: reference_clock_input,
                    cur_lim: current_sense_input,
                    por_ok: stall_timer_node,
                    uv_trip: supply_below_trip,
                    uv_release: supply_above_release,
                    sel_a: count_select_a,
                    sel_b: count_select_b,
                    dir: direction_select,
                    brake: brake_select,
                    run_n: run_stop_n};

    assign access = psel & penable;
    assign mapped = (paddr == bldc_pkg::OFS_PWM_PERIOD) |
                    (paddr == bldc_pkg::OFS_STALL_TIME) |
                    (paddr == bldc_pkg::OFS_STATUS) |
                    (paddr == bldc_pkg::OFS_ERRORS);

    always_comb begin
        n = s;
        {cnt_sel, div_sel} = sel_decode(s.flt.sel_a, s.flt.sel_b);
        comm = commutate(s.flt.hall, s.flt.dir);
        mag = 16'h0000;
        win = 16'(cnt_sel) >> bldc_pkg::LOCK_SHIFT;
        lock_now = s.locked;
        vco_tick = 1'b0;

        n.s1 = pins;
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.flt = (s.s2 & s.s3) | (s.flt & (s.s2 ^ s.s3));
        ref_edge = s.flt.refclk & ~s.ref_prev;
        tach_edge = s.flt.tach & ~s.tach_prev;
        n.ref_prev = s.flt.refclk;
        n.tach_prev = s.flt.tach;
        n.dir_prev = s.flt.dir;
        n.brake_prev = s.flt.brake;
        braking = s.flt.brake &
                  ((s.st == bldc_pkg::ST_RUN) |
                   (s.st == bldc_pkg::ST_SETTLE));
        n.spd_vld = 1'b0;
        n.ph_vld = 1'b0;

        // nco at fclk*div; limitation: reference below pclk / 1024
        if (ref_edge) begin
            n.ref_per = 20'(s.ref_per_cnt + 20'h1);
            n.ref_per_cnt = 20'h0;
            n.loss_cnt = 32'h0;
            n.clk_lost = 1'b0;
        end else begin
            if (s.ref_per_cnt != 20'hfffff) begin
                n.ref_per_cnt = 20'(s.ref_per_cnt + 20'h1);
            end
            if (s.loss_cnt >= 32'(CLK_LOSS_CYC)) begin
                n.clk_lost = 1'b1;
            end else begin
                n.loss_cnt = 32'(s.loss_cnt + 32'h1);
            end
        end
        if (s.ref_per != 20'h0 && !s.clk_lost) begin
            n.nco_acc = 21'(s.nco_acc + 21'(div_sel));
            if (n.nco_acc >= 21'(s.ref_per)) begin
                n.nco_acc = 21'(n.nco_acc - 21'(s.ref_per));
                vco_tick = 1'b1;
            end
        end

        // phase counter wraps every count ticks: tach target is
        if (vco_tick) begin
            n.ph_cnt = (s.ph_cnt >= 11'(cnt_sel - 11'h1)) ? 11'h0
                       : 11'(s.ph_cnt + 11'h1);
            if (s.spd_cnt != 16'hffff) begin
                n.spd_cnt = 16'(s.spd_cnt + 16'h1);
            end
        end
        if (tach_edge) begin
            n.spd_cnt = 16'h0;
            n.spd_skip = ~s.spd_skip;
            if (!s.spd_skip) begin
                // measured one period, next period is skipped
                n.spd_err = 16'(s.spd_cnt - 16'(cnt_sel));
                n.spd_vld = 1'b1;
            end
            n.ph_err = (s.ph_cnt < (cnt_sel >> 1)) ? 16'(s.ph_cnt)
                       : 16'(16'(s.ph_cnt) - 16'(cnt_sel));
            n.ph_vld = 1'b1;
        end

        if (n.spd_vld) begin
            mag = n.spd_err[15] ? 16'(-n.spd_err) : n.spd_err;
            lock_now = (mag <= win);
            n.locked = lock_now;
        end
        if (s.clk_lost) begin
            n.locked = 1'b0;
        end
        if (s.st == bldc_pkg::ST_RUN) begin
            if (n.spd_vld && !lock_now) begin
                n.duty = sat_duty(s.duty, n.spd_err);
            end else if (n.ph_vld && s.locked) begin
                n.duty = sat_duty(s.duty, n.ph_err);
            end
        end
        n.lock_oe = s.locked & (s.st == bldc_pkg::ST_RUN);

        if (s.pwm_cnt >= 16'(s.pwm_period - 16'h1)) begin
            n.pwm_cnt = 16'h0;
            n.pwm_cut = 1'b0;
        end else begin
            n.pwm_cnt = 16'(s.pwm_cnt + 16'h1);
        end
        if (s.flt.cur_lim && !braking) begin
            n.pwm_cut = 1'b1;
        end
        pwm_on = braking | ((s.pwm_cnt < s.duty) & ~s.pwm_cut);

        if (s.flt.uv_trip) begin
            n.uv = 1'b1;
        end else if (s.flt.uv_release) begin
            n.uv = 1'b0;
        end

        if ((s.flt.dir != s.dir_prev) || (s.brake_prev && !s.flt.brake)) begin
            n.dead_cnt = 8'(bldc_pkg::DEAD_CYC);
        end else if (s.dead_cnt != 8'h0) begin
            n.dead_cnt = 8'(s.dead_cnt - 8'h1);
        end

        case (s.st)
            bldc_pkg::ST_OFF: begin
                n.settle_cnt = 32'h0;
                if (!s.flt.run_n) begin
                    n.st = bldc_pkg::ST_SETTLE;
                end
            end
            bldc_pkg::ST_SETTLE: begin
                // oscillator settles before regulation begins
                n.settle_cnt = 32'(s.settle_cnt + 32'h1);
                if (s.flt.run_n) begin
                    n.st = bldc_pkg::ST_OFF;
                end else if (s.settle_cnt >= 32'(SETTLE_CYC)) begin
                    n.st = bldc_pkg::ST_RUN;
                    n.stall_cnt = 32'h0;
                end
            end
            bldc_pkg::ST_RUN: begin
                if (s.locked || braking) begin
                    n.stall_cnt = 32'h0;
                end else begin
                    n.stall_cnt = 32'(s.stall_cnt + 32'h1);
                end
                if (s.flt.run_n) begin
                    n.st = bldc_pkg::ST_OFF;
                end else if (s.stall_cnt >= s.stall_time) begin
                    n.st = bldc_pkg::ST_STALL;
                    n.stop_cnt = 32'h0;
                end
            end
            bldc_pkg::ST_STALL: begin
                // only a held stop or brake, or a low stall node, releases the latch
                if (s.flt.run_n || s.flt.brake) begin
                    n.stop_cnt = 32'(s.stop_cnt + 32'h1);
                end else begin
                    n.stop_cnt = 32'h0;
                end
                if (s.stop_cnt >= 32'(STOP_CLEAR_CYC)) begin
                    n.st = bldc_pkg::ST_OFF;
                end
            end
            default: n.st = bldc_pkg::ST_OFF;
        endcase

        // power saving in stop: loop timing held idle
        if (s.st == bldc_pkg::ST_OFF) begin
            n.nco_acc = 21'h0;
            n.spd_cnt = 16'h0;
            n.ph_cnt = 11'h0;
            n.spd_skip = 1'b0;
            n.duty = 16'h0;
            n.locked = 1'b0;
        end

        n.drv = '{high: 3'b000, low: 3'b000};
        if (s.uv || !s.flt.por_ok) begin
            n.drv = '{high: 3'b000, low: 3'b000};
        end else if (braking) begin
            n.drv = '{high: 3'b111, low: 3'b000};
        end else if (s.dead_cnt != 8'h0) begin
            n.drv = '{high: 3'b000, low: 3'b000};
        end else if (s.st == bldc_pkg::ST_STALL) begin
            n.drv = '{high: 3'b000, low: comm.low};
        end else if (s.st == bldc_pkg::ST_RUN) begin
            n.drv.high = comm.high & {3{pwm_on & ~s.clk_lost}};
            n.drv.low = comm.low;
        end

        if (psel && !penable) begin
            case (paddr)
                bldc_pkg::OFS_PWM_PERIOD: n.rdata = {16'h0, s.pwm_period};
                bldc_pkg::OFS_STALL_TIME: n.rdata = s.stall_time;
                bldc_pkg::OFS_STATUS: begin
                    n.rdata = 32'h0;
                    n.rdata[bldc_pkg::ST_POS_STATE +: 2] = s.st;
                    n.rdata[bldc_pkg::ST_POS_LOCKED] = s.locked;
                    n.rdata[bldc_pkg::ST_POS_CLKLOS] = s.clk_lost;
                    n.rdata[bldc_pkg::ST_POS_UV] = s.uv;
                    n.rdata[bldc_pkg::ST_POS_POR] = ~s.flt.por_ok;
                    n.rdata[bldc_pkg::ST_POS_DUTY +: 16] = s.duty;
                end
                bldc_pkg::OFS_ERRORS: n.rdata = {s.ph_err, s.spd_err};
                default: n.rdata = 32'h0;
            endcase
        end
        if (access && pwrite) begin
            if (paddr == bldc_pkg::OFS_PWM_PERIOD) begin
                n.pwm_period = pwdata[15:0];
            end
            if (paddr == bldc_pkg::OFS_STALL_TIME) begin
                n.stall_time = pwdata;
            end
        end

        // a low stall node resets the run state, the duty and both lock flags of the core
        if (!s.flt.por_ok) begin
            n.st = bldc_pkg::ST_OFF;
            n.duty = 16'h0;
            n.locked = 1'b0;
            n.lock_oe = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.s1 <= bldc_pkg::pins_t'(bldc_pkg::PINS_RST);
            s.s2 <= bldc_pkg::pins_t'(bldc_pkg::PINS_RST);
            s.s3 <= bldc_pkg::pins_t'(bldc_pkg::PINS_RST);
            s.flt <= bldc_pkg::pins_t'(bldc_pkg::PINS_RST);
            s.uv <= 1'b1;
            s.pwm_period <= bldc_pkg::RST_PWM_PERIOD;
            s.stall_time <= bldc_pkg::RST_STALL_TIME;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = access & (~mapped | (pwrite &
                     ((paddr == bldc_pkg::OFS_STATUS) |
                      (paddr == bldc_pkg::OFS_ERRORS))));
    assign {phase_c_high_drive, phase_b_high_drive, phase_a_high_drive} =
           s.drv.high;
    assign {phase_c_low_drive, phase_b_low_drive, phase_a_low_drive} =
           s.drv.low;
    assign speed_locked_flag_o = 1'b0;
    assign speed_locked_flag_oe = s.lock_oe;
    assign speed_error_valid = s.spd_vld;
    assign speed_error = s.spd_err;
    assign phase_error_valid = s.ph_vld;
    assign phase_error = s.ph_err;

endmodule // bldc_speed_loop_controller

// ==== testbench/bldc_monitor.sv ====
// port assertions for the speed loop controller
`timescale 1ns/1ps
module bldc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hall_a_plus,
    input wire logic hall_b_plus,
    input wire logic hall_c_plus,
    input wire logic stall_timer_node,
    input wire logic supply_below_trip,
    input wire logic phase_a_high_drive,
    input wire logic phase_b_high_drive,
    input wire logic phase_c_high_drive,
    input wire logic phase_a_low_drive,
    input wire logic phase_b_low_drive,
    input wire logic phase_c_low_drive,
    input wire logic speed_locked_flag_o,
    input wire logic speed_error_valid,
    input wire logic phase_error_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [2:0] hi = {phase_c_high_drive, phase_b_high_drive,
                           phase_a_high_drive};
    wire logic [2:0] lo = {phase_c_low_drive, phase_b_low_drive,
                           phase_a_low_drive};
    wire logic [2:0] hl = {hall_c_plus, hall_b_plus, hall_a_plus};
    logic last_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) last_ff <= 1'b0;
        else if (phase_error_valid) last_ff <= speed_error_valid;
    end
    no_shoot_a: assert property ((hi & lo) == 3'h0)
        else $error("both drives of one phase on");
    speed_alt_a: assert property (speed_error_valid |-> !last_ff)
        else $error("speed results back to back");
    speed_pair_a: assert property (speed_error_valid |->
        phase_error_valid) else $error("speed result without phase result");
    phase_pulse_a: assert property (phase_error_valid |=>
        !phase_error_valid) else $error("phase result too long");
    hall_equal_a: assert property ((hl == 3'h0 || hl == 3'h7)[*8]
        |=> (hi | lo) == 3'h0) else $error("drive on with equal halls");
    por_off_a: assert property (!stall_timer_node[*8]
        |=> (hi | lo) == 3'h0) else $error("drive on in power-on reset");
    uv_off_a: assert property (supply_below_trip[*8]
        |=> (hi | lo) == 3'h0) else $error("drive on in undervoltage");
    lock_low_a: assert property (speed_locked_flag_o == 1'b0)
        else $error("lock flag drives high");
endmodule // bldc_monitor
bind bldc_speed_loop_controller bldc_monitor i_bldc_monitor (.*);

// ==== testbench/bldc_motor_model.sv ====
// behavioural motor: hall sensors and tach coil, spins at a fixed rate
`timescale 1ns/1ps
module bldc_motor_model #(
    parameter int STEP_CYC = 600
) (
    input  wire logic pclk,
    input  wire logic spin,
    input  wire logic hall_bad,
    output logic      hall_a_plus,
    output logic      hall_b_plus,
    output logic      hall_c_plus,
    output logic      tach_feedback
);
    int         cnt = 0;
    logic [2:0] pos = 3'h0;
    logic [2:0] code;
    initial tach_feedback = 1'b0;
    // two hall steps per tach period; a stopped rotor holds its halls
    always @(posedge pclk) begin
        if (spin && cnt == STEP_CYC - 1) begin
            cnt <= 0;
            pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
            tach_feedback <= ~tach_feedback;
        end else if (spin) cnt <= cnt + 1;
    end
    // comparator reads high where plus sits above minus
    always_comb begin
        case (pos)
            3'h0: code = 3'h1;
            3'h1: code = 3'h3;
            3'h2: code = 3'h2;
            3'h3: code = 3'h6;
            3'h4: code = 3'h4;
            default: code = 3'h5;
        endcase
        if (hall_bad) code = 3'h7;
    end
    assign {hall_c_plus, hall_b_plus, hall_a_plus} = code;
endmodule // bldc_motor_model

// ==== testbench/bldc_speed_loop_controller_tb_top.sv ====
// self-checking bench for the speed loop controller
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
end
module bldc_speed_loop_controller_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        reference_clock_input, tach_feedback, current_sense_input;
    logic        hall_a_plus, hall_b_plus, hall_c_plus, stall_timer_node;
    logic        supply_below_trip, supply_above_release, count_select_a;
    logic        count_select_b, direction_select, brake_select, run_stop_n;
    logic        phase_a_high_drive, phase_b_high_drive, phase_c_high_drive;
    logic        phase_a_low_drive, phase_b_low_drive, phase_c_low_drive;
    logic        speed_locked_flag_o, speed_locked_flag_oe, speed_error_valid;
    logic        phase_error_valid, spin, hall_bad, ref_on;
    logic [15:0] speed_error, phase_error, last_spd;
    int          bad_count, samples_checked, n_ph, n_sp, ref_cnt;
    wire logic [2:0] hi = {phase_c_high_drive, phase_b_high_drive,
                           phase_a_high_drive};
    wire logic [2:0] lo = {phase_c_low_drive, phase_b_low_drive,
                           phase_a_low_drive};
    wire logic [2:0] hl = {hall_c_plus, hall_b_plus, hall_a_plus};
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    bldc_speed_loop_controller #(.STOP_CLEAR_CYC(50), .SETTLE_CYC(20))
        i_bldc_speed_loop_controller (.*);
    bldc_motor_model i_bldc_motor_model (.*);
    // reference clock of 6 us, equal to the tach period at full speed
    always @(posedge pclk) begin
        ref_cnt <= (ref_cnt == 599) ? 0 : ref_cnt + 1;
        if (ref_on && ref_cnt == 599)
            reference_clock_input <= ~reference_clock_input;
        if (phase_error_valid === 1'b1) n_ph <= n_ph + 1;
        if (speed_error_valid === 1'b1) begin
            n_sp <= n_sp + 1;
            last_spd <= speed_error;
        end
    end
    task automatic give_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                @(posedge pclk);
                return;
            end
        end
        bad_count++;
        give_verdict();
    endtask
    task automatic status();
        apb(1'b0, 8'h08, 32'h0);
    endtask
    task automatic sync_tach();
        logic p;
        p = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (!p && tach_feedback) return;
            p = tach_feedback;
        end
        bad_count++;
        give_verdict();
    endtask
    function automatic logic [2:0] low_exp(input logic [2:0] h,
                                           input logic rev);
        case (h)
            3'h1: return rev ? 3'h1 : 3'h2;
            3'h3: return rev ? 3'h1 : 3'h4;
            3'h2: return rev ? 3'h2 : 3'h4;
            3'h6: return rev ? 3'h2 : 3'h1;
            3'h4: return rev ? 3'h4 : 3'h1;
            default: return rev ? 3'h4 : 3'h2;
        endcase
    endfunction
    task automatic regs_test();
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0000_2710)
        apb(1'b1, 8'h00, 32'hffff_1234);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0000_1234)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b1, 8'h08, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task automatic speed_test();
        logic [1:0] sel [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
        int         exp [4] = '{0, -512, 0, 0};
        int         p, s, d;
        spin <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            {count_select_a, count_select_b} <= sel[k];
            idle(2400);
            sync_tach();
            idle(600);
            p = n_ph;
            s = n_sp;
            idle(9600);
            d = int'($signed(last_spd)) - exp[k];
            `CHK(n_ph - p, 8)
            `CHK(n_sp - s, 4)
            `CHK(d < 5 && d > -5, 1'b1)
            `CHK(speed_locked_flag_oe, exp[k] == 0)
        end
        spin <= 1'b0;
    endtask
    task automatic commute_test();
        idle(50);
        `CHK(lo, low_exp(hl, 1'b0))
        direction_select <= 1'b1;
        idle(50);
        `CHK(hi | lo, 3'h0)
        idle(120);
        `CHK(lo, low_exp(hl, 1'b1))
        current_sense_input <= 1'b1;
        idle(20);
        `CHK(hi, 3'h0)
        `CHK(lo, low_exp(hl, 1'b1))
        brake_select <= 1'b1;
        idle(20);
        `CHK({hi, lo}, 6'h38)
        brake_select <= 1'b0;
        current_sense_input <= 1'b0;
        hall_bad <= 1'b1;
        idle(120);
        `CHK(hi | lo, 3'h0)
        hall_bad <= 1'b0;
        direction_select <= 1'b0;
    endtask
    task automatic clock_loss_test();
        ref_on <= 1'b0;
        idle(20700);
        status();
        `CHK(rd[3], 1'b1)
        `CHK(hi, 3'h0)
        ref_on <= 1'b1;
        idle(1300);
        status();
        `CHK(rd[3], 1'b0)
    endtask
    task automatic supply_test();
        stall_timer_node <= 1'b0;
        idle(10);
        status();
        `CHK(rd[5:0], 6'h20)
        stall_timer_node <= 1'b1;
        supply_above_release <= 1'b0;
        supply_below_trip <= 1'b1;
        idle(10);
        supply_below_trip <= 1'b0;
        idle(10);
        status();
        `CHK(rd[4], 1'b1)
        `CHK(hi | lo, 3'h0)
        supply_above_release <= 1'b1;
        idle(10);
        status();
        `CHK(rd[4], 1'b0)
    endtask
    task automatic stall_test();
        apb(1'b1, 8'h04, 32'h100);
        idle(600);
        status();
        `CHK(rd[1:0], 2'h3)
        `CHK(hi, 3'h0)
        brake_select <= 1'b1;
        idle(60);
        status();
        `CHK(rd[1:0], 2'h1)
        brake_select <= 1'b0;
        idle(600);
        status();
        `CHK(rd[1:0], 2'h3)
        run_stop_n <= 1'b1;
        idle(70);
        status();
        `CHK(rd[1:0], 2'h0)
        run_stop_n <= 1'b0;
        idle(8);
        status();
        `CHK(rd[1:0], 2'h1)
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, spin} = '0;
        {hall_bad, brake_select, direction_select, run_stop_n} = '0;
        {current_sense_input, supply_below_trip, reference_clock_input} = '0;
        {stall_timer_node, supply_above_release, ref_on} = 3'h7;
        {count_select_a, count_select_b} = 2'h3;
        {bad_count, samples_checked, n_ph, n_sp, ref_cnt} = '0;
        last_spd = 16'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_test();
        speed_test();
        commute_test();
        clock_loss_test();
        supply_test();
        stall_test();
        give_verdict();
    end
endmodule // bldc_speed_loop_controller_tb_top
